// file: shared/ftac_pkg.sv
// shared constants, types and helpers of the fan start-temperature and acoustic block
package ftac_pkg;

    // ------------------------------------------------------------
    // widths and counts
    // ------------------------------------------------------------
    localparam int TEMP_W   = 8;
    localparam int DUTY_W   = 8;
    localparam int NUM_DYN  = 2;
    localparam int NUM_OP   = 4;
    localparam int NUM_PWM  = 4;
    localparam int ADDR_W   = 8;
    localparam int DATA_W   = 8;

    // ------------------------------------------------------------
    // register offsets
    // ------------------------------------------------------------
    localparam logic [7:0] ADDR_DTC1      = 8'h0B;
    localparam logic [7:0] ADDR_EA1       = 8'h1A;
    localparam logic [7:0] ADDR_EA2       = 8'h1B;
    localparam logic [7:0] ADDR_OP_BASE   = 8'h30;
    localparam logic [7:0] ADDR_FAN_START_TEMPERATURE_BASE = 8'h40;
    localparam logic [7:0] ADDR_HI_BASE   = 8'h44;
    localparam logic [7:0] ADDR_LO_BASE   = 8'h46;
    localparam logic [7:0] ADDR_HYST      = 8'h48;
    localparam logic [7:0] ADDR_DUTY_BASE = 8'h50;

    // ------------------------------------------------------------
    // field positions
    // ------------------------------------------------------------
    localparam int DTC1_EN_LSB  = 0;
    localparam int DTC1_CAP_LSB = 2;
    localparam int EA_EN_LSB    = 0;
    localparam int EA_RATE_A    = 2;
    localparam int EA_RATE_B    = 5;

    // ------------------------------------------------------------
    // reset values
    // ------------------------------------------------------------
    localparam logic [5:0] DTC1_RST = 6'h00;
    localparam logic [7:0] EA_RST   = 8'h00;
    localparam logic [7:0] OP_RST   = 8'h50;
    localparam logic [7:0] FAN_START_TEMPERATURE_RST = 8'h40;
    localparam logic [7:0] HI_RST   = 8'h5A;
    localparam logic [7:0] LO_RST   = 8'h28;
    localparam logic [7:0] HYST_RST = 8'h04;
    localparam logic [7:0] DUTY_RST = 8'h00;

    // lowest start temperature, -64 degrees in two's complement
    localparam logic [7:0] FAN_START_TEMPERATURE_FLOOR = 8'hC0;

    // ------------------------------------------------------------
    // carriers
    // ------------------------------------------------------------
    typedef struct packed {
        logic       en;
        logic [2:0] rate;
    } ftac_ramp_cfg_t;

    typedef struct packed {
        logic [7:0] op;
        logic [7:0] hi;
        logic [7:0] lo;
        logic [7:0] hyst;
    } ftac_zone_t;

    // slots added or removed per update for each three-bit code
    function automatic logic [7:0] ftacRampStep(input logic [2:0] code);
        case (code)
            3'h0:    ftacRampStep = 8'h01;
            3'h1:    ftacRampStep = 8'h02;
            3'h2:    ftacRampStep = 8'h03;
            3'h3:    ftacRampStep = 8'h05;
            3'h4:    ftacRampStep = 8'h08;
            3'h5:    ftacRampStep = 8'h0C;
            3'h6:    ftacRampStep = 8'h18;
            default: ftacRampStep = 8'h30;
        endcase
    endfunction

endpackage

// file: hw/ftac_duty_ramp.sv
// per-output duty rate limiter for the acoustic mode
`timescale 1ns/10ps
module ftac_duty_ramp (
    // clock and reset
    input  wire logic                  clk_sys,
    input  wire logic                  rst_b,
    // update
    input  wire logic                  tick,
    input  wire logic [7:0]            target,
    input  wire ftac_pkg::ftac_ramp_cfg_t cfg,
    // result
    output logic      [7:0]            duty_r
);
    import ftac_pkg::*;

    logic [7:0] step;
    logic [7:0] gap;
    logic [7:0] duty_nxt;

    always_comb begin
        step     = ftacRampStep(cfg.rate);
        gap      = 8'h00;
        duty_nxt = duty_r;
        if (!cfg.en) begin
            duty_nxt = target;
        end else if (target > duty_r) begin
            gap = target - duty_r;
            // duty is 8 bits, so 255 slots is the ceiling and never wraps
            duty_nxt = (gap < step) ? target : duty_r + step;
        end else if (target < duty_r) begin
            gap = duty_r - target;
            duty_nxt = (gap < step) ? target : duty_r - step;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!rst_b) begin
            duty_r <= DUTY_RST;
        end else if (tick) begin
            duty_r <= duty_nxt;
        end
    end

endmodule

// file: hw/ftac_fan_start_temperature_adjust.sv
// one channel of dynamic fan start temperature adjustment
`timescale 1ns/10ps
module ftac_fan_start_temperature_adjust (
    // clock and reset
    input  wire logic                clk_sys,
    input  wire logic                rst_b,
    // control
    input  wire logic                tick,
    input  wire logic                dynEn,
    input  wire logic                progWr,
    input  wire logic [7:0]          progVal,
    // zone inputs
    input  wire logic [7:0]          temp,
    input  wire ftac_pkg::ftac_zone_t zone,
    // result
    output logic      [7:0]          fan_start_temperature_r
);
    import ftac_pkg::*;

    logic        [7:0]  prevTemp_r;
    logic signed [10:0] t;
    logic signed [10:0] tm;
    logic signed [10:0] rise;
    logic signed [10:0] nxt;
    logic        [7:0]  fan_start_temperature_nxt;

    // eleven bits: start temperature minus twice the largest rise minus
    // one reaches -639 and must not wrap before the floor clamp
    always_comb begin
        t    = 11'(signed'(temp));
        tm   = 11'(signed'(fan_start_temperature_r));
        rise = t - 11'(signed'(prevTemp_r));
        nxt  = tm;
        // below the start temperature the loop stays idle
        // hysteresis is a positive width, so it is zero extended
        if (t > tm) begin
            if (t > 11'(signed'(zone.op)) - $signed({3'h0, zone.hyst})
                && rise > 11'sh000) begin
                nxt = nxt - (rise <<< 1);
            end
            if (t > 11'(signed'(zone.op))) begin
                nxt = nxt - 11'sh001;
            end
            if (t < 11'(signed'(zone.lo)) && tm < 11'(signed'(zone.hi))
                && tm < 11'(signed'(zone.op))) begin
                nxt = tm + 11'sh001;
            end
        end
        if (nxt < 11'(signed'(FAN_START_TEMPERATURE_FLOOR))) begin
            nxt = 11'(signed'(FAN_START_TEMPERATURE_FLOOR));
        end
        fan_start_temperature_nxt = nxt[7:0];
    end

    always_ff @(posedge clk_sys) begin
        if (!rst_b) begin
            prevTemp_r <= 8'h00;
        end else if (tick) begin
            prevTemp_r <= temp;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!rst_b) begin
            fan_start_temperature_r <= FAN_START_TEMPERATURE_RST;
        end else if (progWr) begin
            fan_start_temperature_r <= progVal;
        end else if (tick && dynEn) begin
            fan_start_temperature_r <= fan_start_temperature_nxt;
        end
    end

endmodule

// file: hw/ftac_fan_ctrl.sv
// top of the fan start-temperature and acoustic enhancement control block
//
// Summary of operation
// - remote-1 enable set: start temperature adjusts; clear: programmed value held
// - remote-2 enable set: start temperature adjusts; clear: programmed value held
// - adjustments use present temperature, operating point, high and low limits
// - capture bit set: thermal input low copies temperature into operating point
// - capture bit clear: thermal input ignored, operating point kept
// - thermal input is asserted by a low level
// - acoustic mode off: new duty applied at once
// - acoustic mode on: duty change per update limited to a step
// - target above duty: duty rises by the step each update
// - target below duty: duty falls by the step each update
// - acoustic mode enabled separately for each PWM output
// - duty has 255 slots; one slot is the smallest increment
// - three-bit code picks 1, 2, 3, 5, 8, 12, 24 or 48 slots
//
// Our own choice: the address-and-strobe port.
`timescale 1ns/10ps
module ftac_fan_ctrl (
    // clock and reset
    input  wire logic                           clk_sys,
    input  wire logic                           rst_b,
    // register port
    input  wire logic [ftac_pkg::ADDR_W-1:0]    regAddr,
    input  wire logic [ftac_pkg::DATA_W-1:0]    regWrData,
    input  wire logic                           regWr,
    input  wire logic                           regRd,
    output logic      [ftac_pkg::DATA_W-1:0]    regRdData,
    // thermal alert, active low
    input  wire logic                           thermAlertIn_b,
    // measurement timebase and temperatures
    input  wire logic                           monTick,
    input  wire logic [ftac_pkg::NUM_OP-1:0][7:0] remoteTemp,
    // duty from the automatic loop
    input  wire logic [ftac_pkg::NUM_PWM-1:0][7:0] dutyCalc,
    // results
    output logic      [ftac_pkg::NUM_PWM-1:0][7:0] dutyOut,
    output logic      [ftac_pkg::NUM_DYN-1:0][7:0] fanStartTemp
);
    import ftac_pkg::*;

    // ------------------------------------------------------------
    // register storage
    // ------------------------------------------------------------
    logic [5:0]              dtc1_r;
    logic [7:0]              ea1_r;
    logic [7:0]              ea2_r;
    logic [NUM_OP-1:0][7:0]  op_r;
    logic [NUM_DYN-1:0][7:0] hi_r;
    logic [NUM_DYN-1:0][7:0] lo_r;
    logic [7:0]              hyst_r;
    logic [7:0]              regRdData_r;
    logic [7:0]              rd_nxt;

    // ------------------------------------------------------------
    // write decode
    // ------------------------------------------------------------
    logic                    wrDtc1;
    logic                    wrEa1;
    logic                    wrEa2;
    logic                    wrHyst;
    logic [NUM_OP-1:0]       wrOp;
    logic [NUM_DYN-1:0]      wrTmin;
    logic [NUM_DYN-1:0]      wrHi;
    logic [NUM_DYN-1:0]      wrLo;
    logic                    thermLow;

    assign wrDtc1   = regWr && regAddr == ADDR_DTC1;
    assign wrEa1    = regWr && regAddr == ADDR_EA1;
    assign wrEa2    = regWr && regAddr == ADDR_EA2;
    assign wrHyst   = regWr && regAddr == ADDR_HYST;
    assign thermLow = !thermAlertIn_b;

    always_comb begin
        for (int k = 0; k < NUM_OP; k++) begin
            wrOp[k] = regWr && regAddr == ADDR_OP_BASE + 8'(k);
        end
        for (int k = 0; k < NUM_DYN; k++) begin
            wrTmin[k] = regWr && regAddr == ADDR_FAN_START_TEMPERATURE_BASE + 8'(k);
            wrHi[k]   = regWr && regAddr == ADDR_HI_BASE + 8'(k);
            wrLo[k]   = regWr && regAddr == ADDR_LO_BASE + 8'(k);
        end
    end

    // ------------------------------------------------------------
    // control registers
    // ------------------------------------------------------------
    always_ff @(posedge clk_sys) begin
        if (!rst_b) begin
            dtc1_r <= DTC1_RST;
        end else if (wrDtc1) begin
            dtc1_r <= regWrData[5:0];
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!rst_b) begin
            ea1_r <= EA_RST;
        end else if (wrEa1) begin
            ea1_r <= regWrData;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!rst_b) begin
            ea2_r <= EA_RST;
        end else if (wrEa2) begin
            ea2_r <= regWrData;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!rst_b) begin
            hyst_r <= HYST_RST;
        end else if (wrHyst) begin
            hyst_r <= regWrData;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!rst_b) begin
            hi_r <= {NUM_DYN{HI_RST}};
        end else begin
            for (int k = 0; k < NUM_DYN; k++) begin
                if (wrHi[k]) begin
                    hi_r[k] <= regWrData;
                end
            end
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!rst_b) begin
            lo_r <= {NUM_DYN{LO_RST}};
        end else begin
            for (int k = 0; k < NUM_DYN; k++) begin
                if (wrLo[k]) begin
                    lo_r[k] <= regWrData;
                end
            end
        end
    end

    // ------------------------------------------------------------
    // operating points with thermal capture
    // ------------------------------------------------------------
    // capture beats a software write in the same cycle: the alert is
    // the fresher fact about where the processor starts throttling
    always_ff @(posedge clk_sys) begin
        if (!rst_b) begin
            op_r <= {NUM_OP{OP_RST}};
        end else begin
            for (int k = 0; k < NUM_OP; k++) begin
                if (thermLow && dtc1_r[DTC1_CAP_LSB + k]) begin
                    op_r[k] <= remoteTemp[k];
                end else if (wrOp[k]) begin
                    op_r[k] <= regWrData;
                end
            end
        end
    end

    // ------------------------------------------------------------
    // dynamic start temperature channels
    // ------------------------------------------------------------
    ftac_zone_t [NUM_DYN-1:0] zone;

    always_comb begin
        for (int k = 0; k < NUM_DYN; k++) begin
            zone[k].op   = op_r[k];
            zone[k].hi   = hi_r[k];
            zone[k].lo   = lo_r[k];
            zone[k].hyst = hyst_r;
        end
    end

    for (genvar g = 0; g < NUM_DYN; g++) begin : gDyn
        ftac_fan_start_temperature_adjust uTmin (
            .clk_sys (clk_sys),
            .rst_b   (rst_b),
            .tick    (monTick),
            .dynEn   (dtc1_r[DTC1_EN_LSB + g]),
            .progWr  (wrTmin[g]),
            .progVal (regWrData),
            .temp    (remoteTemp[g]),
            .zone    (zone[g]),
            .fan_start_temperature_r  (fanStartTemp[g])
        );
    end

    // ------------------------------------------------------------
    // acoustic rate limiting per output
    // ------------------------------------------------------------
    ftac_ramp_cfg_t [NUM_PWM-1:0] rampCfg;

    // each output owns its own enable and rate field
    always_comb begin
        rampCfg[0].en   = ea1_r[EA_EN_LSB];
        rampCfg[0].rate = ea1_r[EA_RATE_A +: 3];
        rampCfg[1].en   = ea1_r[EA_EN_LSB + 1];
        rampCfg[1].rate = ea1_r[EA_RATE_B +: 3];
        rampCfg[2].en   = ea2_r[EA_EN_LSB];
        rampCfg[2].rate = ea2_r[EA_RATE_A +: 3];
        rampCfg[3].en   = ea2_r[EA_EN_LSB + 1];
        rampCfg[3].rate = ea2_r[EA_RATE_B +: 3];
    end

    for (genvar g = 0; g < NUM_PWM; g++) begin : gPwm
        ftac_duty_ramp uRamp (
            .clk_sys (clk_sys),
            .rst_b   (rst_b),
            .tick    (monTick),
            .target  (dutyCalc[g]),
            .cfg     (rampCfg[g]),
            .duty_r  (dutyOut[g])
        );
    end

    // ------------------------------------------------------------
    // read path
    // ------------------------------------------------------------
    // unmapped offsets and reserved bits read as zero
    always_comb begin
        rd_nxt = 8'h00;
        case (regAddr)
            ADDR_DTC1:          rd_nxt = {2'h0, dtc1_r};
            ADDR_EA1:           rd_nxt = ea1_r;
            ADDR_EA2:           rd_nxt = ea2_r;
            ADDR_HYST:          rd_nxt = hyst_r;
            ADDR_OP_BASE:       rd_nxt = op_r[0];
            ADDR_OP_BASE + 8'h01: rd_nxt = op_r[1];
            ADDR_OP_BASE + 8'h02: rd_nxt = op_r[2];
            ADDR_OP_BASE + 8'h03: rd_nxt = op_r[3];
            ADDR_FAN_START_TEMPERATURE_BASE:     rd_nxt = fanStartTemp[0];
            ADDR_FAN_START_TEMPERATURE_BASE + 8'h01: rd_nxt = fanStartTemp[1];
            ADDR_HI_BASE:       rd_nxt = hi_r[0];
            ADDR_HI_BASE + 8'h01: rd_nxt = hi_r[1];
            ADDR_LO_BASE:       rd_nxt = lo_r[0];
            ADDR_LO_BASE + 8'h01: rd_nxt = lo_r[1];
            ADDR_DUTY_BASE:     rd_nxt = dutyOut[0];
            ADDR_DUTY_BASE + 8'h01: rd_nxt = dutyOut[1];
            ADDR_DUTY_BASE + 8'h02: rd_nxt = dutyOut[2];
            ADDR_DUTY_BASE + 8'h03: rd_nxt = dutyOut[3];
            default:            rd_nxt = 8'h00;
        endcase
    end

    // data stand only in the cycle after the strobe
    always_ff @(posedge clk_sys) begin
        if (!rst_b) begin
            regRdData_r <= 8'h00;
        end else if (regRd) begin
            regRdData_r <= rd_nxt;
        end else begin
            regRdData_r <= 8'h00;
        end
    end

    assign regRdData = regRdData_r;

endmodule

// file: test/ftac_fan_ctrl_sva.sv
// port-level assertions for the fan start-temperature and acoustic block
`timescale 1ns/10ps
module ftac_fan_ctrl_sva
    import ftac_pkg::*;
(
    // clock and reset
    input wire logic                              clk_sys,
    input wire logic                              rst_b,
    // register port
    input wire logic [ftac_pkg::ADDR_W-1:0]       regAddr,
    input wire logic [ftac_pkg::DATA_W-1:0]       regWrData,
    input wire logic                              regWr,
    input wire logic                              regRd,
    input wire logic [ftac_pkg::DATA_W-1:0]       regRdData,
    // thermal alert and timebase
    input wire logic                              thermAlertIn_b,
    input wire logic                              monTick,
    // data
    input wire logic [ftac_pkg::NUM_OP-1:0][7:0]  remoteTemp,
    input wire logic [ftac_pkg::NUM_PWM-1:0][7:0] dutyCalc,
    input wire logic [ftac_pkg::NUM_PWM-1:0][7:0] dutyOut,
    input wire logic [ftac_pkg::NUM_DYN-1:0][7:0] fanStartTemp
);
    // ----------
    // shadow state
    // ----------
    localparam logic [7:0] STEP [8] = '{8'h01, 8'h02, 8'h03, 8'h05,
                                        8'h08, 8'h0C, 8'h18, 8'h30};
    logic [5:0]      dtc_r;
    logic [1:0][7:0] ea_r;
    logic [7:0]      op0_r;
    logic [3:0][7:0] expNext;

    always_ff @(posedge clk_sys) begin
        if (!rst_b) begin
            dtc_r <= DTC1_RST;
            ea_r  <= '0;
        end else if (regWr && regAddr == ADDR_DTC1) begin
            dtc_r <= regWrData[5:0];
        end else if (regWr && regAddr[7:1] == ADDR_EA1[7:1]) begin
            ea_r[regAddr[0]] <= regWrData;
        end
    end

    // capture wins over a software write in the same cycle
    always_ff @(posedge clk_sys) begin
        if (!rst_b) begin
            op0_r <= OP_RST;
        end else if (!thermAlertIn_b && dtc_r[DTC1_CAP_LSB]) begin
            op0_r <= remoteTemp[0];
        end else if (regWr && regAddr == ADDR_OP_BASE) begin
            op0_r <= regWrData;
        end
    end

    function automatic logic [7:0] rampNext(input logic [7:0] cur,
        input logic [7:0] tgt, input logic en, input logic [2:0] code);
        logic [7:0] d;
        d = (tgt > cur) ? tgt - cur : cur - tgt;
        if (!en || d < STEP[code]) return tgt;
        return (tgt > cur) ? cur + STEP[code] : cur - STEP[code];
    endfunction

    always_comb begin
        for (int i = 0; i < 4; i++) begin
            expNext[i] = rampNext(dutyOut[i], dutyCalc[i],
                ea_r[i/2][i%2], ea_r[i/2][2+3*(i%2)+:3]);
        end
    end

    // ----------
    // assertions
    // ----------
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rst_b);

    a_read_idle: assert property (!regRd |=> regRdData == '0)
        else $error("read data not zero outside a read answer");
    a_dtc_readback: assert property (
        regRd && regAddr == ADDR_DTC1 |=> regRdData == {2'h0, $past(dtc_r)})
        else $error("control register read back wrong");
    a_op_capture: assert property (
        regRd && regAddr == ADDR_OP_BASE |=> regRdData == $past(op0_r))
        else $error("operating point value wrong");
    a_duty_hold: assert property (
        !monTick |=> $stable(dutyOut))
        else $error("duty moved without an update");
    a_duty_free: assert property (
        monTick && !ea_r[0][0] |=> dutyOut[0] == $past(dutyCalc[0]))
        else $error("duty not applied at once");
    a_duty_ramp: assert property (
        monTick |=> dutyOut == $past(expNext))
        else $error("duty step wrong");
    a_tmin1_hold: assert property (
        !(monTick && dtc_r[0]) && !(regWr && regAddr == ADDR_FAN_START_TEMPERATURE_BASE)
        |=> $stable(fanStartTemp[0]))
        else $error("remote 1 start temperature moved");
    a_tmin2_hold: assert property (
        !(monTick && dtc_r[1]) && !(regWr && regAddr == 8'h41)
        |=> $stable(fanStartTemp[1]))
        else $error("remote 2 start temperature moved");
    a_fan_start_temperature_load: assert property (
        regWr && regAddr == ADDR_FAN_START_TEMPERATURE_BASE |=> fanStartTemp[0] == $past(regWrData))
        else $error("start temperature write not loaded");

    c_capture: cover property (!thermAlertIn_b && dtc_r[2]);
    c_ramp_up: cover property (monTick && ea_r[0][0] && dutyCalc[0] > dutyOut[0]);
    c_fan_start_temperature_move: cover property (monTick && dtc_r[0] ##1 $changed(fanStartTemp[0]));
endmodule

bind ftac_fan_ctrl ftac_fan_ctrl_sva chk (
    .clk_sys(clk_sys), .rst_b(rst_b), .regAddr(regAddr),
    .regWrData(regWrData), .regWr(regWr), .regRd(regRd),
    .regRdData(regRdData), .thermAlertIn_b(thermAlertIn_b),
    .monTick(monTick), .remoteTemp(remoteTemp), .dutyCalc(dutyCalc),
    .dutyOut(dutyOut), .fanStartTemp(fanStartTemp)
);

// file: test/ftac_hot_model.sv
// model of the processor hot signal wired to the thermal alert input
`timescale 1ns/10ps
module ftac_hot_model (
    // clock
    input  wire logic clk_sys,
    // request from the bench
    input  wire logic hotReq,
    // pulled-up line, pulled low while hot
    output logic      thermAlertIn_b = 1'b1
);
    // released line returns to the pull-up level
    always @(posedge clk_sys) begin
        thermAlertIn_b <= !hotReq;
    end
endmodule

// file: test/ftac_fan_ctrl_test.sv
// self-checking bench for the fan start-temperature and acoustic block
`timescale 1ns/10ps
module ftac_fan_ctrl_test;
    import ftac_pkg::*;

    // ----------
    // signals
    // ----------
    localparam logic [7:0] STEPS [8] = '{8'h01, 8'h02, 8'h03, 8'h05,
                                         8'h08, 8'h0C, 8'h18, 8'h30};
    localparam logic [7:0] RA [8] = '{ADDR_DTC1, ADDR_EA1, ADDR_EA2,
        ADDR_OP_BASE, ADDR_FAN_START_TEMPERATURE_BASE, ADDR_HI_BASE, ADDR_HYST, 8'hFF};
    localparam logic [7:0] RV [8] = '{8'h00, EA_RST, EA_RST, OP_RST,
        FAN_START_TEMPERATURE_RST, HI_RST, HYST_RST, 8'h00};
    logic            clk_sys = 1'b0;
    logic            rst_b, regWr, regRd, monTick, hotReq, thermAlertIn_b;
    logic [7:0]      regAddr, regWrData, regRdData, cur, stp, tgt;
    logic [3:0][7:0] remoteTemp, dutyCalc, dutyOut;
    logic [1:0][7:0] fanStartTemp;
    int              fails = 0;
    int              n_compared = 0;
    int              o;

    always #25 clk_sys = ~clk_sys;

    ftac_fan_ctrl DUT (
        .clk_sys(clk_sys), .rst_b(rst_b), .regAddr(regAddr),
        .regWrData(regWrData), .regWr(regWr), .regRd(regRd),
        .regRdData(regRdData), .thermAlertIn_b(thermAlertIn_b),
        .monTick(monTick), .remoteTemp(remoteTemp), .dutyCalc(dutyCalc),
        .dutyOut(dutyOut), .fanStartTemp(fanStartTemp));
    ftac_hot_model processor_hot_output (.clk_sys(clk_sys), .hotReq(hotReq),
        .thermAlertIn_b(thermAlertIn_b));

    // ----------
    // tasks
    // ----------
    task automatic check(input string what, input logic [7:0] exp,
                         input logic [7:0] got);
        n_compared++;
        if (got !== exp) begin
            $display("ERROR %s expected %h seen %h", what, exp, got);
            fails++;
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk_sys);
        regWr     <= 1'b1;
        regAddr   <= a;
        regWrData <= d;
        @(posedge clk_sys);
        regWr <= 1'b0;
    endtask

    task automatic rdchk(input logic [7:0] a, input logic [7:0] exp);
        @(posedge clk_sys);
        regRd   <= 1'b1;
        regAddr <= a;
        @(posedge clk_sys);
        regRd <= 1'b0;
        #1 check($sformatf("register %h", a), exp, regRdData);
    endtask

    task automatic tick();
        @(posedge clk_sys);
        monTick <= 1'b1;
        @(posedge clk_sys);
        monTick <= 1'b0;
        #1;
    endtask

    task automatic close_out();
        if (fails == 0 && n_compared > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask

    initial begin
        repeat (100000) @(posedge clk_sys);
        $display("ERROR run time limit expected end seen hang");
        fails++;
        close_out();
    end

    // ----------
    // main sequence
    // ----------
    initial begin
        rst_b = 1'b0;
        {regWr, regRd, monTick, hotReq} = 4'h0;
        {regAddr, regWrData} = 16'h0000;
        remoteTemp = '0;
        dutyCalc = '0;
        repeat (6) @(posedge clk_sys);
        rst_b <= 1'b1;
        for (int i = 0; i < 8; i++) rdchk(RA[i], RV[i]);
        wr(8'hFF, 8'hA5);
        wr(ADDR_DTC1, 8'hC0);
        rdchk(ADDR_DTC1, 8'h00);
        rdchk(8'hFF, 8'h00);
        // thermal capture with alternating masks
        remoteTemp <= {8'h64, 8'h63, 8'h62, 8'h61};
        for (int p = 0; p < 2; p++) begin
            for (int k = 0; k < 4; k++) wr(ADDR_OP_BASE + k[7:0], 8'h11);
            wr(ADDR_DTC1, p ? 8'h28 : 8'h14);
            hotReq <= 1'b1;
            repeat (3) @(posedge clk_sys);
            hotReq <= 1'b0;
            repeat (2) @(posedge clk_sys);
            for (int k = 0; k < 4; k++)
                rdchk(ADDR_OP_BASE + k[7:0], (k % 2 == p) ? 8'h61 + k[7:0] : 8'h11);
        end
        // start temperature per channel
        wr(ADDR_OP_BASE, OP_RST);
        wr(ADDR_OP_BASE + 8'h01, OP_RST);
        for (int c = 0; c < 2; c++) begin
            wr(ADDR_DTC1, 8'h00);
            wr(ADDR_FAN_START_TEMPERATURE_BASE, 8'h40);
            wr(ADDR_FAN_START_TEMPERATURE_BASE + 8'h01, 8'h40);
            remoteTemp <= {8'h00, 8'h00, 8'h50, 8'h50};
            tick();
            wr(ADDR_DTC1, 8'h01 << c);
            remoteTemp <= {8'h00, 8'h00, 8'h52, 8'h52};
            tick();
            check("start temp on", 8'h40 - 8'h05, fanStartTemp[c]);
            check("start temp off", 8'h40, fanStartTemp[1-c]);
            wr(ADDR_FAN_START_TEMPERATURE_BASE + c[7:0], 8'h10);
            remoteTemp <= {8'h00, 8'h00, 8'h20, 8'h20};
            tick();
            check("start temp up", 8'h11, fanStartTemp[c]);
        end
        // acoustic ramp, every step code, up then down
        for (int code = 0; code < 8; code++) begin
            o = code % 4;
            wr(ADDR_EA1, 8'h00);
            wr(ADDR_EA2, 8'h00);
            dutyCalc <= '0;
            tick();
            check("duty cleared", 8'h00, dutyOut[o]);
            wr(o < 2 ? ADDR_EA1 : ADDR_EA2,
               (8'h01 << (o % 2)) | (code[7:0] << (2 + 3 * (o % 2))));
            stp = STEPS[code];
            cur = 8'h00;
            for (int t = 0; t < 2; t++) begin
                tgt = t ? 8'h0A : 8'hC8;
                dutyCalc <= {4{tgt}};
                for (int n = 0; n < 256 && cur != tgt; n++) begin
                    tick();
                    if (t == 0) cur = (tgt - cur < stp) ? tgt : cur + stp;
                    else cur = (cur - tgt < stp) ? tgt : cur - stp;
                    check("ramped duty", cur, dutyOut[o]);
                    check("free duty", tgt, dutyOut[(o+1)%4]);
                end
            end
        end
        close_out();
    end
endmodule
